// ---- inc/charge_seq_pkg.sv ----
/*
  Constants, types and register map of the charge-cycle sequencer.
  Assumes a 100 MHz system clock and an AHB-Lite register bus.
*/
`default_nettype none
package charge_seq_pkg;

  // ==========================================================================
  // Clock and base timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned OSC_HZ        = 200;
  localparam int unsigned MAINS_HZ      = 50;
  localparam int unsigned OSC_CYCLES    = CLK_HZ / OSC_HZ;
  localparam int unsigned UNIT_MS       = 100;
  localparam logic [4:0]  MAINS_UNIT_DIV = 5'(MAINS_HZ * UNIT_MS / 1000);
  localparam logic [4:0]  OSC_UNIT_DIV   = 5'(OSC_HZ * UNIT_MS / 1000);

  // ==========================================================================
  // Divider factors
  localparam logic [14:0] MAINS_DIV     = 15'd100;
  localparam logic [14:0] OSC_DIV       = 15'd400;
  localparam logic [14:0] FOLLOW_HALF_H = 15'd900;
  localparam logic [14:0] FOLLOW_ONE_H  = 15'd1800;
  localparam logic [14:0] FOLLOW_12_H   = 15'd21600;

  // ==========================================================================
  // Sequence times, in ms, and their counts in 100 ms units
  localparam int unsigned DETECT_MS     = 2000;
  localparam int unsigned BLINK_MS      = 500;
  localparam int unsigned PULSE_ON_MS   = 100;
  localparam int unsigned PULSE_OFF_MS  = 1200;
  localparam int unsigned TRICKLE_ON_MS = 100;
  localparam int unsigned TRICKLE_OFF_MS = 16800;
  localparam logic [7:0] DETECT_UNITS   = 8'(DETECT_MS / UNIT_MS);
  localparam logic [7:0] BLINK_UNITS    = 8'(BLINK_MS / UNIT_MS);
  localparam logic [7:0] PULSE_ON_U     = 8'(PULSE_ON_MS / UNIT_MS);
  localparam logic [7:0] PULSE_PER_U    = 8'((PULSE_ON_MS + PULSE_OFF_MS) / UNIT_MS);
  localparam logic [7:0] TRICKLE_ON_U   = 8'(TRICKLE_ON_MS / UNIT_MS);
  localparam logic [7:0] TRICKLE_PER_U  = 8'((TRICKLE_ON_MS + TRICKLE_OFF_MS) / UNIT_MS);

  // ==========================================================================
  // PWM: step count per ramp level, least value keeps the rate at 50 kHz or below
  localparam logic [7:0] PWM_STEP_MIN   = 8'h08;
  localparam logic [7:0] PWM_STEP_RST   = 8'h08;
  localparam logic [8:0] PWM_DUTY_RST   = 9'h100;

  // ==========================================================================
  // Register map (byte addresses) and fields
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] PWM_OFS        = 8'h04;
  localparam logic [7:0] STATUS_OFS     = 8'h08;
  localparam int unsigned CTRL_MAINS_BIT   = 0;
  localparam int unsigned CTRL_EXT_BIT     = 1;
  localparam int unsigned CTRL_TERM_BIT    = 2;
  localparam int unsigned CTRL_RESTART_BIT = 3;
  localparam int unsigned PWM_DUTY_LSB  = 0;
  localparam int unsigned PWM_STEP_LSB  = 16;
  localparam logic [3:0] CTRL_RST       = 4'h0;

  // ==========================================================================
  // Strap codes
  localparam logic [1:0] SEL_OPEN       = 2'h0;
  localparam logic [1:0] SEL_GND        = 2'h1;
  localparam logic [1:0] SEL_REF        = 2'h2;

  typedef enum logic [2:0] {
    ST_NOBATT, ST_DETECT, ST_DISCH, ST_CHARGE, ST_TRICKLE, ST_FAIL
  } state_e;

  // Comparator flags, high means the condition holds
  typedef struct packed {
    logic contact;
    logic disch_stop;
    logic overvolt;
    logic overtemp;
  } flags_s;

endpackage
`default_nettype wire

// ---- src/tick_divider.sv ----
/*
  Tick divider: emits a one-cycle pulse every FACTOR input ticks.
  Assumes ticks are one-cycle pulses in the CLK domain.
*/
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
  parameter int unsigned W = 15
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Control
  input  wire logic         clr,
  input  wire logic         tick,
  input  wire logic [W-1:0] factor,
  // Result
  output logic              pulse_q
);

  logic [W-1:0] cnt_q;

  // ==========================================================================
  // Count ticks, wrap at factor
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end
    else if (ce)
    begin
      pulse_q <= 1'b0;
      if (clr)
        cnt_q <= '0;
      else if (tick)
      begin
        if (cnt_q >= factor - W'(1))
        begin
          cnt_q   <= '0;
          pulse_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + W'(1);
      end
    end
  end

endmodule // tick_divider
`default_nettype wire

// ---- src/charge_cycle_sequencer.sv ----
/*
  Battery charge-cycle sequencer with timer dividers, PWM gating, LED status
  and an AHB-Lite register slave.
  Assumes comparator flags and pin clocks synchronous to CLK, one AHB master.

  // How it works
  // - Three-level strap picks 0.5 h, 1 h or 12 h charge time.
  // - Short settings keep charge output on for the whole period.
  // - Twelve-hour setting pulses charge 100 ms on, 1200 ms off.
  // - Base clock from 200 Hz oscillator, 50 Hz mains or external clock.
  // - Mains divided by 100, oscillator by 400, ORed onto timer node.
  // - Follow-up divider is 900, 1800 or 21600 per strap setting.
  // - Outside drive of the timer node clocks the follow-up divider.
  // - PWM gates charge and discharge, duty 0 to 100 percent.
  // - With mains base, oscillator may run PWM up to 50 kHz.
  // - No battery after power-up: red LED steady.
  // - Contact: wait two seconds, then discharge with red LED blinking.
  // - Discharge-stop starts charge and timer together, green LED blinks.
  // - Over-voltage or over-temperature hold both drivers inactive.
  // - Second interruption: policy terminates with red steady or continues.
  // - After charge time, trickle pulses 0.1 s on, 16.8 s off.
  // - Charge time is base period times first and follow-up factors.
  // - Discharge ends on discharge-stop; grounded input charges at once.
  // - Thermal cut-off applies in charge and discharge phases.
*/
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module charge_cycle_sequencer #(
  parameter int unsigned OSC_CYCLES_P = charge_seq_pkg::OSC_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  input  wire logic                   CE,
  // AHB-Lite slave
  input  wire logic                   HSEL,
  input  wire logic [31:0]            HADDR,
  input  wire logic [1:0]             HTRANS,
  input  wire logic                   HWRITE,
  input  wire logic [2:0]             HSIZE,
  input  wire logic [31:0]            HWDATA,
  input  wire logic                   HREADY,
  output logic [31:0]                 HRDATA,
  output logic                        HREADYOUT,
  output logic                        HRESP,
  // Clock sources and strap
  input  wire logic                   MAINS_SYNC,
  input  wire logic                   TIMER_NODE_IN,
  input  wire logic [1:0]             CHARGE_TIME_SEL,
  // Comparator flags
  input  wire charge_seq_pkg::flags_s SENSE,
  // Drivers and LEDs
  output logic                        CHARGE_OUT,
  output logic                        DISCH_OUT,
  output logic                        LED_RED,
  output logic                        LED_GREEN
);
  import charge_seq_pkg::*;

  // ==========================================================================
  // Input synchronisers: first stage feeds only the second
  flags_s     flg_m_q;
  flags_s     flg_q;
  logic [1:0] pin_m_q;
  logic [1:0] pin_q;
  logic [1:0] pin_d1_q;
  logic       mains_edge;
  logic       node_edge;

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      flg_m_q  <= '0;
      flg_q    <= '0;
      pin_m_q  <= 2'h0;
      pin_q    <= 2'h0;
      pin_d1_q <= 2'h0;
    end
    else if (CE)
    begin
      flg_m_q  <= SENSE;
      flg_q    <= flg_m_q;
      pin_m_q  <= {TIMER_NODE_IN, MAINS_SYNC};
      pin_q    <= pin_m_q;
      pin_d1_q <= pin_q;
    end
  end

  assign mains_edge = pin_q[0] & ~pin_d1_q[0];
  assign node_edge  = pin_q[1] & ~pin_d1_q[1];

  // ==========================================================================
  // Registers
  logic       mains_sel_q;
  logic       ext_only_q;
  logic       fail_term_q;
  logic       restart_q;
  logic [8:0] duty_q;
  logic [7:0] pwm_step_q;
  logic [7:0] addr_q;
  logic       wr_q;
  logic       sel_q;
  logic [31:0] status_w;
  logic [31:0] rd_w;
  state_e     state_q;
  logic [1:0] strap_q;
  logic [1:0] intr_cnt_q;
  logic       drv_chg_q;
  logic       drv_dis_q;

  // Address phase capture; zero wait states, always OKAY
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      addr_q    <= 8'h00;
      wr_q      <= 1'b0;
      sel_q     <= 1'b0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else if (CE)
    begin
      sel_q <= HSEL & HREADY & HTRANS[1];
      wr_q  <= HWRITE;
      if (HSEL & HREADY & HTRANS[1])
        addr_q <= HADDR[7:0];
    end
  end

  // Software writes steer sources, policy and PWM
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      {restart_q, fail_term_q, ext_only_q, mains_sel_q} <= CTRL_RST;
      duty_q     <= PWM_DUTY_RST;
      pwm_step_q <= PWM_STEP_RST;
    end
    else if (CE)
    begin
      restart_q <= 1'b0;
      if (sel_q & wr_q & (addr_q == CTRL_OFS))
      begin
        mains_sel_q <= HWDATA[CTRL_MAINS_BIT];
        ext_only_q  <= HWDATA[CTRL_EXT_BIT];
        fail_term_q <= HWDATA[CTRL_TERM_BIT];
        restart_q   <= HWDATA[CTRL_RESTART_BIT];
      end
      if (sel_q & wr_q & (addr_q == PWM_OFS))
      begin
        duty_q <= (HWDATA[PWM_DUTY_LSB +: 9] > PWM_DUTY_RST) ? PWM_DUTY_RST
                                                           : HWDATA[PWM_DUTY_LSB +: 9];
        // Floor on the step keeps the ramp at 50 kHz or slower
        pwm_step_q <= (HWDATA[PWM_STEP_LSB +: 8] < PWM_STEP_MIN) ? PWM_STEP_MIN
                                                               : HWDATA[PWM_STEP_LSB +: 8];
      end
    end
  end

  assign status_w = {16'h0000, strap_q, intr_cnt_q, flg_q,
                     LED_GREEN, LED_RED, drv_dis_q, drv_chg_q, 1'b0, state_q};

  always_comb
  begin
    rd_w = 32'h0000_0000;
    unique case (HADDR[7:0])
      CTRL_OFS:   rd_w = {28'h0, 1'b0, fail_term_q, ext_only_q, mains_sel_q};
      PWM_OFS:    rd_w = {8'h00, pwm_step_q, 7'h00, duty_q};
      STATUS_OFS: rd_w = status_w;
      default:    rd_w = 32'h0000_0000;
    endcase
  end

  // Read data latched at the address edge so it stands in the data phase
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      HRDATA <= 32'h0000_0000;
    else if (CE && HSEL && HREADY && HTRANS[1] && !HWRITE)
      HRDATA <= rd_w;
  end

  // ==========================================================================
  // Clock generation and dividers
  logic        osc_tick;
  logic        mains_div_p;
  logic        osc_div_p;
  logic        timer_node;
  logic        unit_tick;
  logic        charge_end_p;
  logic        base_tick;
  logic [14:0] follow_fac;
  logic        timer_clr;

  // Free-running oscillator tick at nominal 200 Hz
  tick_divider #(.W(19)) u_osc (
    .clk(CLK), .rst(SYS_RST), .ce(CE), .clr(1'b0), .tick(1'b1),
    .factor(19'(OSC_CYCLES_P)), .pulse_q(osc_tick)
  );

  // First stage dividers; each runs only from its selected source
  tick_divider #(.W(15)) u_mains_div (
    .clk(CLK), .rst(SYS_RST), .ce(CE), .clr(1'b0),
    .tick(mains_edge & mains_sel_q & ~ext_only_q),
    .factor(MAINS_DIV), .pulse_q(mains_div_p)
  );
  tick_divider #(.W(15)) u_osc_div (
    .clk(CLK), .rst(SYS_RST), .ce(CE), .clr(1'b0),
    .tick(osc_tick & ~mains_sel_q & ~ext_only_q),
    .factor(OSC_DIV), .pulse_q(osc_div_p)
  );

  // Outside drive on the node is ORed with both divider pulses, allowing fast test sequences
  assign timer_node = mains_div_p | osc_div_p | node_edge;

  always_comb
  begin
    unique case (strap_q)
      SEL_GND: follow_fac = FOLLOW_ONE_H;
      SEL_REF: follow_fac = FOLLOW_12_H;
      default: follow_fac = FOLLOW_HALF_H;
    endcase
  end

  // Charge time = base period x first factor x follow-up factor
  tick_divider #(.W(15)) u_follow (
    .clk(CLK), .rst(SYS_RST), .ce(CE), .clr(timer_clr), .tick(timer_node),
    .factor(follow_fac), .pulse_q(charge_end_p)
  );

  // Base tick for blink and delays never comes from the timer node
  assign base_tick = mains_sel_q ? mains_edge : osc_tick;
  tick_divider #(.W(5)) u_unit (
    .clk(CLK), .rst(SYS_RST), .ce(CE), .clr(1'b0), .tick(base_tick),
    .factor(mains_sel_q ? MAINS_UNIT_DIV : OSC_UNIT_DIV), .pulse_q(unit_tick)
  );

  // ==========================================================================
  // Sequencer
  logic [7:0] wait_q;
  logic [7:0] phase_q;
  logic [7:0] blink_cnt_q;
  logic       blink_q;
  logic       fault;
  logic       fault_d1_q;

  assign fault     = flg_q.overvolt | flg_q.overtemp;
  assign timer_clr = (state_q == ST_DISCH) & flg_q.disch_stop;

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_q    <= ST_NOBATT;
      strap_q    <= SEL_OPEN;
      wait_q     <= 8'h00;
      intr_cnt_q <= 2'h0;
      fault_d1_q <= 1'b0;
    end
    else if (CE)
    begin
      fault_d1_q <= fault;
      if (restart_q || (!flg_q.contact && state_q != ST_NOBATT))
      begin
        state_q    <= ST_NOBATT;   // Lost contact or software restart
        intr_cnt_q <= 2'h0;
      end
      else
      begin
        unique case (state_q)
          ST_NOBATT:
          begin
            strap_q <= CHARGE_TIME_SEL;
            wait_q  <= 8'h00;
            if (flg_q.contact)
              state_q <= ST_DETECT;
          end
          ST_DETECT:
          begin
            if (unit_tick)
              wait_q <= wait_q + 8'h01;
            if (wait_q >= DETECT_UNITS)
              state_q <= ST_DISCH;
          end
          ST_DISCH, ST_CHARGE:
          begin
            // Rising fault counts as one interruption
            if (fault & ~fault_d1_q)
            begin
              if (intr_cnt_q != 2'h2)
                intr_cnt_q <= intr_cnt_q + 2'h1;
              if (intr_cnt_q == 2'h1 && fail_term_q)
                state_q <= ST_FAIL;
            end
            else if (state_q == ST_DISCH && flg_q.disch_stop)
              state_q <= ST_CHARGE;
            else if (state_q == ST_CHARGE && charge_end_p)
              state_q <= ST_TRICKLE;
          end
          ST_TRICKLE, ST_FAIL:
            state_q <= state_q;
        endcase
      end
    end
  end

  // Pulse phase counter in 100 ms units, restarted at each state change
  state_e st_d1_q;
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      phase_q <= 8'h00;
      st_d1_q <= ST_NOBATT;
    end
    else if (CE)
    begin
      st_d1_q <= state_q;
      if (st_d1_q != state_q)
        phase_q <= 8'h00;
      else if (unit_tick)
      begin
        if (state_q == ST_TRICKLE)
          phase_q <= (phase_q >= TRICKLE_PER_U - 8'h01) ? 8'h00 : phase_q + 8'h01;
        else
          phase_q <= (phase_q >= PULSE_PER_U - 8'h01) ? 8'h00 : phase_q + 8'h01;
      end
    end
  end

  // Blink at half-second toggles from the base clock
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      blink_cnt_q <= 8'h00;
      blink_q     <= 1'b0;
    end
    else if (CE && unit_tick)
    begin
      if (blink_cnt_q >= BLINK_UNITS - 8'h01)
      begin
        blink_cnt_q <= 8'h00;
        blink_q     <= ~blink_q;
      end
      else
        blink_cnt_q <= blink_cnt_q + 8'h01;
    end
  end

  // ==========================================================================
  // PWM ramp; comparison against duty gives 0..256 of 256 levels
  logic [7:0] step_cnt_q;
  logic [7:0] ramp_q;
  logic       pwm_on;

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      step_cnt_q <= 8'h00;
      ramp_q     <= 8'h00;
    end
    else if (CE)
    begin
      if (step_cnt_q >= pwm_step_q - 8'h01)
      begin
        step_cnt_q <= 8'h00;
        ramp_q     <= ramp_q + 8'h01;
      end
      else
        step_cnt_q <= step_cnt_q + 8'h01;
    end
  end

  assign pwm_on = {1'b0, ramp_q} < duty_q;

  // ==========================================================================
  // Drivers and LEDs, all registered
  logic chg_req;

  always_comb
  begin
    chg_req = 1'b0;
    unique case (state_q)
      ST_CHARGE:
        if (strap_q == SEL_REF)
          chg_req = phase_q < PULSE_ON_U;
        else
          chg_req = 1'b1;
      ST_TRICKLE: chg_req = phase_q < TRICKLE_ON_U;
      default:    chg_req = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      drv_chg_q  <= 1'b0;
      drv_dis_q  <= 1'b0;
      CHARGE_OUT <= 1'b0;
      DISCH_OUT  <= 1'b0;
    end
    else if (CE)
    begin
      // Cut-off blocks both drivers for as long as it lasts
      drv_chg_q  <= chg_req & ~fault;
      drv_dis_q  <= (state_q == ST_DISCH) & ~fault;
      CHARGE_OUT <= chg_req & ~fault & pwm_on;
      DISCH_OUT  <= (state_q == ST_DISCH) & ~fault & pwm_on;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      LED_RED   <= 1'b0;
      LED_GREEN <= 1'b0;
    end
    else if (CE)
    begin
      LED_RED   <= (state_q == ST_NOBATT) | (state_q == ST_FAIL)
                 | ((state_q == ST_DISCH) & blink_q);
      LED_GREEN <= ((state_q == ST_CHARGE) & blink_q)
                 | (state_q == ST_TRICKLE);
    end
  end

endmodule // charge_cycle_sequencer
`default_nettype wire

// ---- test/seq_checker_assertions.sv ----
/* Port checker for the charge-cycle sequencer.
   Assumes one clock, CE held high by the bench. */
`timescale 1ns/10ps
`default_nettype none
module seq_checker #(
  parameter int unsigned OSC_CYCLES_P = 20
) (
  // Clock and reset
  input wire logic                   CLK,
  input wire logic                   SYS_RST,
  // Bus
  input wire logic                   CE,
  input wire logic                   HSEL,
  input wire logic [31:0]            HADDR,
  input wire logic [1:0]             HTRANS,
  input wire logic                   HWRITE,
  input wire logic                   HREADY,
  input wire logic [31:0]            HRDATA,
  input wire logic                   HREADYOUT,
  input wire logic                   HRESP,
  // Sequencer side
  input wire charge_seq_pkg::flags_s SENSE,
  input wire logic                   CHARGE_OUT,
  input wire logic                   DISCH_OUT,
  input wire logic                   LED_RED,
  input wire logic                   LED_GREEN
);
  import charge_seq_pkg::*;
  // ==========================================================
  // Helpers
  logic        rd_req;
  logic [15:0] held_q;
  assign rd_req = CE && HSEL && HREADY && HTRANS[1] && !HWRITE;
  // Contact age; even a fast mains base needs 200 cycles for 2 s
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      held_q <= 16'h0000;
    else if (!SENSE.contact)
      held_q <= 16'h0000;
    else if (held_q != 16'hFFFF)
      held_q <= held_q + 16'h0001;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  AST_BUS_OKAY:
    assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
  AST_FAULT_OFF:
    assert property ((SENSE.overvolt || SENSE.overtemp) [*5] |-> !CHARGE_OUT && !DISCH_OUT)
    else $error("driver on during fault");
  AST_NOBATT_RED:
    assert property (!SENSE.contact [*6] |-> LED_RED && !CHARGE_OUT && !DISCH_OUT)
    else $error("no battery but red off or driver on");
  AST_DETECT_WAIT:
    assert property ($rose(DISCH_OUT) |-> held_q > 16'd190) else $error("discharge too early");
  AST_ONE_DRIVER:
    assert property (!(CHARGE_OUT && DISCH_OUT)) else $error("charge and discharge together");
  AST_ONE_LED:
    assert property (!(LED_RED && LED_GREEN)) else $error("both leds lit");
  AST_UNMAPPED_ZERO:
    assert property (rd_req && HADDR[7:0] > 8'h08 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_CTRL_UPPER_ZERO:
    assert property (rd_req && HADDR[7:0] == 8'h00 |=> HRDATA[31:3] == 29'h0)
    else $error("control upper bits not zero");
  // Main scenarios reached
  cover property ($rose(DISCH_OUT));
  cover property ($rose(CHARGE_OUT));
  cover property ($rose(LED_GREEN));
endmodule // seq_checker
`default_nettype wire

// ---- test/battery_model.sv ----
/* Battery, sensors and switches beside the sequencer.
   Assumes flags are already synchronous to the clock. */
`timescale 1ns/10ps
`default_nettype none
module battery_model (
  // Clock and driver from the device
  input wire logic                 clk,
  input wire logic                 disch_on,
  // Bench commands
  input wire logic                 insert,
  input wire logic                 heat,
  input wire logic                 surge,
  input wire logic                 no_predis,
  // Comparator flags to the device
  output var charge_seq_pkg::flags_s sense
);
  import charge_seq_pkg::*;
  logic [11:0] cell_q;
  // ==========================================================
  // Cell level sinks only while discharge is driven
  always_ff @(posedge clk)
  begin
    if (!insert)
      cell_q <= 12'hC00;
    else if (disch_on && cell_q != 12'h000)
      cell_q <= cell_q - 12'h001;
  end
  // Flags settle right after the edge
  always_ff @(posedge clk)
  begin
    sense.contact    <= insert;
    sense.disch_stop <= insert && (no_predis || cell_q == 12'h000);
    sense.overvolt   <= insert && surge;
    sense.overtemp   <= insert && heat;
  end
endmodule // battery_model
`default_nettype wire

// ---- test/testbench.sv ----
/* Self-checking bench of the sequencer over AHB-Lite.
   Assumes a shortened oscillator base and no other slave. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import charge_seq_pkg::*;
  logic        CLK = 1'b0, SYS_RST = 1'b1, CE = 1'b1, HSEL = 1'b1, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, d;
  logic [1:0]  HTRANS = 2'h0, CHARGE_TIME_SEL = 2'h0;
  logic        HREADYOUT, HRESP, CHARGE_OUT, DISCH_OUT, LED_RED, LED_GREEN;
  logic        TIMER_NODE_IN = 1'b0, insert = 1'b0, heat = 1'b0, surge = 1'b0;
  logic        no_predis = 1'b0, MAINS_SYNC = 1'b0;
  flags_s      SENSE;
  int          error_cnt = 0, n_tests = 0, cyc = 0, t0, bad;
  // ==========================================================
  // Clock, design and battery
  always #5 CLK = ~CLK;
  charge_cycle_sequencer #(.OSC_CYCLES_P(20)) i_charge_cycle_sequencer (
    .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .MAINS_SYNC(MAINS_SYNC), .TIMER_NODE_IN(TIMER_NODE_IN),
    .CHARGE_TIME_SEL(CHARGE_TIME_SEL), .SENSE(SENSE), .CHARGE_OUT(CHARGE_OUT),
    .DISCH_OUT(DISCH_OUT), .LED_RED(LED_RED), .LED_GREEN(LED_GREEN));
  battery_model i_battery_model (.clk(CLK), .disch_on(DISCH_OUT), .insert(insert),
    .heat(heat), .surge(surge), .no_predis(no_predis), .sense(SENSE));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single word transfer; hold each phase until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
                      output logic [31:0] r);
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= v;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  // Poll the state field, bounded
  task automatic wait_st(input logic [2:0] s);
    d = 32'hFFFF_FFFF;
    for (int i = 0; i < 6000 && d[2:0] !== s; i++)
      xfer(1'b0, STATUS_OFS, 32'h0, d);
    chk(32'(d[2:0]), 32'(s));
  endtask
  // Timer node edges, four cycles apart
  task automatic pulses(input int n);
    repeat (n)
    begin
      TIMER_NODE_IN <= 1'b1;
      repeat (2) @(posedge CLK);
      TIMER_NODE_IN <= 1'b0;
      repeat (2) @(posedge CLK);
    end
  endtask
  task automatic fault(input logic ov);
    if (ov) surge <= 1'b1;
    else heat <= 1'b1;
    repeat (8) @(posedge CLK);
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, well above the 21k cycles the run needs
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    // Mains stand-in, one period per 40 cycles
    if (cyc % 20 == 0)
      MAINS_SYNC <= ~MAINS_SYNC;
    if (cyc == 40000)
    begin
      error_cnt++;
      conclude();
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    repeat (2) @(posedge CLK);
    chk(32'(LED_RED), 32'h1);
    xfer(1'b0, CTRL_OFS, 32'h0, d);
    chk(d, 32'h0);
    xfer(1'b0, PWM_OFS, 32'h0, d);
    chk(d, {8'h0, PWM_STEP_RST, 7'h0, PWM_DUTY_RST});
    xfer(1'b0, 8'h40, 32'h0, d);
    chk(d, 32'h0);
    // Timer node from bench only; oscillator base keeps running
    xfer(1'b1, CTRL_OFS, 32'h2, d);
    xfer(1'b0, CTRL_OFS, 32'h0, d);
    chk(d, 32'h2);
    for (int s = 2; s >= 0; s--)
    begin
      CHARGE_TIME_SEL <= 2'(s);
      repeat (3) @(posedge CLK);
      xfer(1'b0, STATUS_OFS, 32'h0, d);
      chk(32'(d[15:14]), 32'(s));
    end
    // Detect delay is 20 units of 400 cycles
    insert <= 1'b1;
    t0 = cyc;
    wait_st(3'h2);
    chk(32'(cyc - t0 > 7500 && cyc - t0 < 8600), 32'h1);
    chk({31'h0, DISCH_OUT}, 32'h1);
    fault(1'b0);
    chk({31'h0, DISCH_OUT}, 32'h0);
    heat <= 1'b0;
    xfer(1'b0, STATUS_OFS, 32'h0, d);
    chk(32'(d[13:12]), 32'h1);
    wait_st(3'h3);
    chk({31'h0, CHARGE_OUT}, 32'h1);
    bad = 0;
    repeat (300) @(posedge CLK) bad += int'(CHARGE_OUT !== 1'b1);
    chk(32'(bad), 32'h0);
    // Half duty with the step below its floor: 128 levels of 8 cycles
    xfer(1'b1, PWM_OFS, 32'h0000_0080, d);
    xfer(1'b0, PWM_OFS, 32'h0, d);
    chk(d, {8'h0, PWM_STEP_MIN, 7'h0, 9'h080});
    bad = 0;
    t0 = 0;
    repeat (2048) @(posedge CLK)
    begin
      bad += int'(CHARGE_OUT === 1'b1);
      t0 += int'(LED_GREEN === 1'b1);
    end
    chk(32'(bad), 32'd1024);
    chk(32'(t0 > 0 && t0 < 2048), 32'h1);
    xfer(1'b1, PWM_OFS, 32'h0008_0100, d);
    fault(1'b1);
    chk({31'h0, CHARGE_OUT}, 32'h0);
    surge <= 1'b0;
    pulses(899);
    repeat (4) @(posedge CLK);
    xfer(1'b0, STATUS_OFS, 32'h0, d);
    chk(32'(d[13:12]), 32'h2);
    chk(32'(d[2:0]), 32'h3);
    pulses(1);
    wait_st(3'h4);
    chk({31'h0, LED_GREEN}, 32'h1);
    // Pull the battery, then charge at once and fail on the second fault
    insert <= 1'b0;
    wait_st(3'h0);
    // Mains base now: 5 edges of 40 cycles per unit halves the detect delay
    xfer(1'b1, CTRL_OFS, 32'h7, d);
    no_predis <= 1'b1;
    insert <= 1'b1;
    t0 = cyc;
    wait_st(3'h3);
    chk(32'(cyc - t0 > 3700 && cyc - t0 < 4300), 32'h1);
    fault(1'b0);
    heat <= 1'b0;
    repeat (8) @(posedge CLK);
    fault(1'b0);
    wait_st(3'h5);
    chk({30'h0, LED_RED, CHARGE_OUT}, 32'h2);
    conclude();
  end
endmodule // testbench
bind charge_cycle_sequencer seq_checker #(.OSC_CYCLES_P(OSC_CYCLES_P)) i_seq_checker (
  .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SENSE(SENSE), .CHARGE_OUT(CHARGE_OUT),
  .DISCH_OUT(DISCH_OUT), .LED_RED(LED_RED), .LED_GREEN(LED_GREEN));
`default_nettype wire
